// [design/sar_adc_sequencer_12bit.sv]
// Register file, trigger selection and successive-approximation sequencer of a 12-bit ADC
//
// What this block does
// - Successive approximation yields the 12-bit result
// - Ten setup plus four clocks per bit
// - On completion load result, set done, flag
// - Done reads zero during conversion
// - Start-source field selects trigger event
// - Channel field selects input or 1.8V node
// - Align zero: high-justified result placement
// - Align one: low-justified result placement
// - Clock field divides system clock 1/2/4/8
// - Irq flag sets; cleared by write or acknowledge
`timescale 1ns/10ps
`include "sar_adc_regs.svh"
module sar_adc_sequencer_12bit
    import sar_adc_pkg::*;
#(
    parameter int RESULT_BITS = `ADC_RESULT_BITS
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // Avalon-MM slave
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Trigger events from timers, same clock
    input wire logic t1_match_a_in,
    input wire logic t4_overflow_in,
    input wire logic t4_match_a_in,
    input wire logic t4_match_b_in,
    input wire logic t4_match_c_in,
    // Processor state
    input wire logic stop_mode_in,
    input wire logic irq_ack_in,
    // Analog multiplexer and converter core
    output logic [3:0] input_channel_select_out,
    output logic ref_select_out,
    output logic mux_enable_out,
    output logic sample_out,
    output logic [RESULT_BITS-1:0] dac_code_out,
    input wire logic comparator_in,
    // Interrupt
    output logic irq_out
);
    if (RESULT_BITS != `ADC_RESULT_BITS) begin : bad_width
        $error("Result layout serves only twelve bits");
    end

    localparam int PHASE_W = 2;
    localparam logic [3:0] SETUP_LAST = 4'(`ADC_SETUP_CLOCKS - 1);
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(`ADC_CLOCKS_PER_BIT - 1);

    // ****************************************
    // Control registers
    // ****************************************
    logic module_power_enable_r;
    logic soft_convert_start_r;
    logic ref_select_r;
    logic conversion_done_flag_r;
    logic [3:0] input_channel_select_r;
    logic conv_irq_flag_r;
    logic [2:0] start_source_select_r;
    logic align_low_r;
    logic [1:0] conv_clock_divider_r;
    logic irq_enable_r;
    logic [7:0] result_high_r;
    logic [7:0] result_low_r;

    // ****************************************
    // Bus decode
    // ****************************************
    logic access_done_r;
    logic [7:0] word_index;
    logic bus_request;
    logic take;
    logic wr_ctrl_low;
    logic wr_ctrl_high;
    logic wr_irq_enable;
    logic wr_irq_clear;
    logic [7:0] wdata;
    logic [31:0] rdata;

    assign word_index = avs_address_in[9:2];
    assign bus_request = avs_read_in || avs_write_in;
    // One wait cycle per access: waitrequest drops on the second cycle of the request
    // A frozen clock enable keeps the bus stalled, so no access is answered and then lost
    assign avs_waitrequest_out = bus_request && !(access_done_r && clk_en_in);
    assign take = bus_request && access_done_r && clk_en_in;
    assign wdata = avs_writedata_in[7:0];
    assign wr_ctrl_low = take && avs_write_in && avs_byteenable_in[0]
        && word_index == `ADC_IDX_CTRL_LOW;
    assign wr_ctrl_high = take && avs_write_in && avs_byteenable_in[0]
        && word_index == `ADC_IDX_CTRL_HIGH;
    assign wr_irq_enable = take && avs_write_in && avs_byteenable_in[0]
        && word_index == `ADC_IDX_IRQ_ENABLE;
    assign wr_irq_clear = take && avs_write_in && avs_byteenable_in[0]
        && word_index == `ADC_IDX_IRQ_CLEAR;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            access_done_r <= 1'b0;
        end else if (clk_en_in) begin
            access_done_r <= bus_request && !access_done_r;
        end
    end

    // ****************************************
    // Sequencer state
    // ****************************************
    conv_state_e state_r;
    logic [3:0] setup_count_r;
    logic [PHASE_W-1:0] phase_r;
    logic [3:0] bit_index_r;
    logic [RESULT_BITS-1:0] sar_r;
    logic tick;
    logic busy;
    logic trigger;
    logic finish;

    assign busy = state_r != CONV_IDLE;

    always_comb begin
        unique case (start_source_select_r)
            3'h0: trigger = soft_convert_start_r;
            3'h1: trigger = t1_match_a_in;
            3'h2: trigger = t4_overflow_in;
            3'h3: trigger = t4_match_a_in;
            3'h4: trigger = t4_match_b_in;
            3'h5: trigger = t4_match_c_in;
            default: trigger = 1'b0;
        endcase
    end

    conv_clock_divider u_divider (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .run_in(busy),
        .div_sel_in(conv_clock_divider_r),
        .tick_out(tick)
    );

    assign finish = state_r == CONV_BITS && tick && phase_r == PHASE_LAST
        && bit_index_r == 4'h0;

    // Stop mode or power-off aborts a running conversion; a late trigger is ignored
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= CONV_IDLE;
            setup_count_r <= 4'h0;
            phase_r <= '0;
            bit_index_r <= 4'h0;
        end else if (clk_en_in) begin
            if (!module_power_enable_r || stop_mode_in) begin
                state_r <= CONV_IDLE;
            end else begin
                unique case (state_r)
                    CONV_IDLE: begin
                        if (trigger) begin
                            state_r <= CONV_SETUP;
                            setup_count_r <= 4'h0;
                        end
                    end
                    CONV_SETUP: begin
                        if (tick) begin
                            if (setup_count_r == SETUP_LAST) begin
                                state_r <= CONV_BITS;
                                phase_r <= '0;
                                bit_index_r <= 4'(RESULT_BITS - 1);
                            end else begin
                                setup_count_r <= setup_count_r + 4'h1;
                            end
                        end
                    end
                    CONV_BITS: begin
                        if (tick) begin
                            phase_r <= phase_r + PHASE_W'(1);
                            if (phase_r == PHASE_LAST) begin
                                if (bit_index_r == 4'h0) begin
                                    state_r <= CONV_IDLE;
                                end else begin
                                    bit_index_r <= bit_index_r - 4'h1;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Trial bit set on first phase, kept or dropped on the last phase
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sar_r <= '0;
        end else if (clk_en_in) begin
            if (state_r == CONV_SETUP && tick && setup_count_r == SETUP_LAST) begin
                sar_r <= '0;
            end else if (state_r == CONV_BITS && tick) begin
                if (phase_r == '0) begin
                    sar_r[bit_index_r] <= 1'b1;
                end else if (phase_r == PHASE_LAST) begin
                    sar_r[bit_index_r] <= comparator_in;
                end
            end
        end
    end

    assign dac_code_out = sar_r;
    assign sample_out = state_r == CONV_SETUP;
    assign mux_enable_out = module_power_enable_r && !stop_mode_in;
    assign input_channel_select_out = input_channel_select_r;
    assign ref_select_out = ref_select_r;

    // ****************************************
    // Result registers
    // ****************************************
    logic [RESULT_BITS-1:0] final_code;
    assign final_code = {sar_r[RESULT_BITS-1:1], comparator_in};

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_high_r <= 8'h00;
            result_low_r <= 8'h00;
        end else if (clk_en_in && finish) begin
            if (align_low_r) begin
                result_high_r <= {4'h0, final_code[11:8]};
                result_low_r <= final_code[7:0];
            end else begin
                result_high_r <= final_code[11:4];
                result_low_r <= {final_code[3:0], 4'h0};
            end
        end
    end

    // ****************************************
    // Control register writes
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            module_power_enable_r <= 1'b0;
            ref_select_r <= 1'b0;
            input_channel_select_r <= 4'h0;
            start_source_select_r <= 3'h0;
            align_low_r <= 1'b0;
            conv_clock_divider_r <= 2'h0;
            irq_enable_r <= 1'b0;
        end else if (clk_en_in) begin
            if (stop_mode_in) begin
                module_power_enable_r <= 1'b0;
            end else if (wr_ctrl_low) begin
                module_power_enable_r <= wdata[`ADC_CL_POWER_BIT];
            end
            if (wr_ctrl_low) begin
                ref_select_r <= wdata[`ADC_CL_REFSEL_BIT];
                input_channel_select_r <= wdata[`ADC_CL_CHAN_LSB +: 4];
            end
            if (wr_ctrl_high) begin
                start_source_select_r <= wdata[`ADC_CH_TRIG_LSB +: 3];
                align_low_r <= wdata[`ADC_CH_ALIGN_BIT];
                conv_clock_divider_r <= wdata[`ADC_CH_CLKDIV_LSB +: 2];
            end
            if (wr_irq_enable) begin
                irq_enable_r <= wdata[0];
            end
        end
    end

    // Start bit lives one cycle at most: it is consumed or dropped at once
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            soft_convert_start_r <= 1'b0;
        end else if (clk_en_in) begin
            soft_convert_start_r <= wr_ctrl_low && wdata[`ADC_CL_START_BIT]
                && wdata[`ADC_CL_POWER_BIT]
                && start_source_select_r == 3'h0 && !busy;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conversion_done_flag_r <= 1'b0;
        end else if (clk_en_in) begin
            if (stop_mode_in || (wr_ctrl_low && !wdata[`ADC_CL_POWER_BIT])) begin
                conversion_done_flag_r <= 1'b0;
            end else if (finish) begin
                conversion_done_flag_r <= 1'b1;
            end else if (state_r == CONV_IDLE && trigger && module_power_enable_r) begin
                conversion_done_flag_r <= 1'b0;
            end
        end
    end

    // Completion wins over a clear that lands in the same cycle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conv_irq_flag_r <= 1'b0;
        end else if (clk_en_in) begin
            if (finish) begin
                conv_irq_flag_r <= 1'b1;
            end else if (irq_ack_in) begin
                conv_irq_flag_r <= 1'b0;
            end else if (wr_ctrl_high && !wdata[`ADC_CH_IRQ_BIT]) begin
                conv_irq_flag_r <= 1'b0;
            end else if (wr_irq_clear && wdata[0]) begin
                conv_irq_flag_r <= 1'b0;
            end
        end
    end

    assign irq_out = conv_irq_flag_r && irq_enable_r;

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (word_index)
            `ADC_IDX_CTRL_LOW: rdata[7:0] = {module_power_enable_r, 1'b0, ref_select_r,
                conversion_done_flag_r && !busy, input_channel_select_r};
            `ADC_IDX_CTRL_HIGH: rdata[7:0] = {conv_irq_flag_r, 1'b0, start_source_select_r,
                align_low_r, conv_clock_divider_r};
            `ADC_IDX_RESULT_LOW: rdata[7:0] = result_low_r;
            `ADC_IDX_RESULT_HIGH: rdata[7:0] = result_high_r;
            `ADC_IDX_IRQ_STATUS: rdata[0] = conv_irq_flag_r;
            `ADC_IDX_IRQ_ENABLE: rdata[0] = irq_enable_r;
            `ADC_IDX_STOP_MODE: rdata[0] = stop_mode_in;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (clk_en_in) begin
            if (bus_request && !access_done_r && avs_read_in) begin
                avs_readdata_out <= rdata;
            end
        end
    end
endmodule

// [include/sar_adc_regs.svh]
// Register offsets, field positions, reset values and timing counts of the ADC sequencer
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// ****************************************
// Register word offsets (byte address = 4 x index)
// ****************************************
`define ADC_IDX_CTRL_LOW 8'h9C
`define ADC_IDX_CTRL_HIGH 8'h9D
`define ADC_IDX_RESULT_LOW 8'h9E
`define ADC_IDX_RESULT_HIGH 8'h9F
`define ADC_IDX_IRQ_STATUS 8'hA0
`define ADC_IDX_IRQ_ENABLE 8'hA1
`define ADC_IDX_IRQ_CLEAR 8'hA2
`define ADC_IDX_STOP_MODE 8'hA3

// ****************************************
// Control low fields
// ****************************************
`define ADC_CL_POWER_BIT 7
`define ADC_CL_START_BIT 6
`define ADC_CL_REFSEL_BIT 5
`define ADC_CL_DONE_BIT 4
`define ADC_CL_CHAN_LSB 0

// ****************************************
// Control high fields
// ****************************************
`define ADC_CH_IRQ_BIT 7
`define ADC_CH_TRIG_LSB 3
`define ADC_CH_ALIGN_BIT 2
`define ADC_CH_CLKDIV_LSB 0

// ****************************************
// Reset values
// ****************************************
`define ADC_CTRL_LOW_RESET 8'h00
`define ADC_CTRL_HIGH_RESET 8'h00

// ****************************************
// Conversion timing in converter clocks
// ****************************************
`define ADC_SETUP_CLOCKS 10
`define ADC_CLOCKS_PER_BIT 4
`define ADC_RESULT_BITS 12
`define ADC_TOTAL_CLOCKS 58

`endif

// [include/sar_adc_pkg.sv]
// Types shared by the ADC sequencer files
package sar_adc_pkg;
    typedef enum logic [2:0] {
        TRIG_SOFT,
        TRIG_T1_A,
        TRIG_T4_OVF,
        TRIG_T4_A,
        TRIG_T4_B,
        TRIG_T4_C
    } start_source_e;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_SETUP,
        CONV_BITS
    } conv_state_e;
endpackage

// [design/conv_clock_divider.sv]
// Conversion clock enable generator dividing the system clock by 1, 2, 4 or 8
`timescale 1ns/10ps
module conv_clock_divider (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // Control
    input wire logic run_in,
    input wire logic [1:0] div_sel_in,
    // Output
    output logic tick_out
);
    logic [2:0] count_r;
    logic [2:0] limit;

    always_comb begin
        unique case (div_sel_in)
            2'h0: limit = 3'h0;
            2'h1: limit = 3'h1;
            2'h2: limit = 3'h3;
            2'h3: limit = 3'h7;
        endcase
    end

    // Counter restarts with every conversion so the first tick is a full period away
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_r <= 3'h0;
        end else if (clk_en_in) begin
            if (!run_in || count_r >= limit) begin
                count_r <= 3'h0;
            end else begin
                count_r <= count_r + 3'h1;
            end
        end
    end

    assign tick_out = run_in && (count_r >= limit);
endmodule

// [tb/sar_adc_props.sv]
// Concurrent checks on the ports of the ADC sequencer
`timescale 1ns/10ps
module sar_adc_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register bus
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Processor state
    input wire logic stop_mode_in,
    input wire logic irq_ack_in,
    // Converter side and interrupt
    input wire logic [3:0] input_channel_select_out,
    input wire logic mux_enable_out,
    input wire logic sample_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    logic req;
    assign req = avs_read_in | avs_write_in;

    // ****************************************
    // Bus timing
    // ****************************************
    a_wait_first_cycle: assert property (req && !$past(req) |-> avs_waitrequest_out)
        else $error("waitrequest low in first cycle of a request");
    a_wait_one_state: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("more than one wait state");
    a_read_upper_zero: assert property (avs_read_in && !avs_waitrequest_out
        |-> avs_readdata_out[31:8] == 24'h0) else $error("read data upper bits not zero");
    a_unmapped_reads_zero: assert property (avs_read_in && !avs_waitrequest_out
        && (avs_address_in < 10'h270 || avs_address_in > 10'h28F) |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");

    // ****************************************
    // Conversion control
    // ****************************************
    a_start_needs_power: assert property ($rose(sample_out) |-> mux_enable_out)
        else $error("conversion started while disabled");
    a_stop_halts: assert property (stop_mode_in |=> !mux_enable_out && !sample_out)
        else $error("stop mode did not disable the converter");
    a_setup_min_len: assert property ($rose(sample_out) |-> sample_out [*8])
        else $error("setup phase too short");
    a_setup_bounded: assert property ($rose(sample_out) |-> ##[1:90] !sample_out)
        else $error("setup phase too long");
    a_chan_from_write: assert property ($changed(input_channel_select_out)
        |-> $past(avs_write_in) && !$past(avs_waitrequest_out) && $past(avs_address_in) >= 10'h270
        && $past(avs_address_in) <= 10'h273) else $error("channel changed without write");
    a_irq_fall_cause: assert property ($fell(irq_out) |-> $past(irq_ack_in)
        || ($past(avs_write_in) && !$past(avs_waitrequest_out)))
        else $error("interrupt dropped without clear");
endmodule

bind sar_adc_sequencer_12bit sar_adc_checker sar_adc_checker_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .stop_mode_in(stop_mode_in), .irq_ack_in(irq_ack_in),
    .input_channel_select_out(input_channel_select_out), .mux_enable_out(mux_enable_out),
    .sample_out(sample_out), .irq_out(irq_out));

// [tb/sar_front_model.sv]
// Behavioural analog multiplexer and comparator facing the ADC sequencer
`timescale 1ns/10ps
module sar_front_model (
    // Converter control
    input wire logic [3:0] input_channel_select_in,
    input wire logic mux_enable_in,
    input wire logic [11:0] dac_code_in,
    // Level of each channel, code 15 is the internal supply node
    input wire logic [11:0] level_in [16],
    // Comparator result
    output logic comparator_out
);
    // Ideal comparator settles at once, so conversion time is not limited here
    // A disabled multiplexer passes nothing, so the comparator reads low
    assign comparator_out = mux_enable_in
        && (level_in[input_channel_select_in] >= dac_code_in);
endmodule

// [tb/tb_sar_adc_sequencer_12bit.sv]
// Self-checking bench of the ADC sequencer with a converter front-end model
`timescale 1ns/10ps
module tb_sar_adc_sequencer_12bit;
    localparam logic [9:0] A_CL = 10'h270;
    localparam logic [9:0] A_CH = 10'h274;
    localparam logic [9:0] A_RL = 10'h278;
    localparam logic [9:0] A_RH = 10'h27C;
    localparam logic [9:0] A_ST = 10'h280;
    localparam logic [9:0] A_EN = 10'h284;
    localparam logic [9:0] A_CLR = 10'h288;
    localparam int LIMIT = 60000;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [9:0] avs_address_in = 10'h000;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [4:0] tim = 5'h00;
    logic stop_mode_in = 1'b0;
    logic irq_ack_in = 1'b0;
    logic [3:0] chan;
    logic mux_en, smp, cmp, irq, s_q, i_q, refs;
    logic [11:0] dac;
    logic [11:0] level [16];
    int seed = 32'hc9a1;
    int failures = 0, comparisons = 0, cyc = 0, t_fall = 0, bits_len = 0;

    sar_adc_sequencer_12bit sar_adc_sequencer_12bit_inst (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_byteenable_in(4'hF),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .t1_match_a_in(tim[0]),
        .t4_overflow_in(tim[1]), .t4_match_a_in(tim[2]), .t4_match_b_in(tim[3]),
        .t4_match_c_in(tim[4]), .stop_mode_in(stop_mode_in), .irq_ack_in(irq_ack_in),
        .input_channel_select_out(chan), .ref_select_out(refs), .mux_enable_out(mux_en),
        .sample_out(smp), .dac_code_out(dac), .comparator_in(cmp), .irq_out(irq));
    sar_front_model sar_front_model_inst (
        .input_channel_select_in(chan), .mux_enable_in(mux_en), .dac_code_in(dac),
        .level_in(level), .comparator_out(cmp));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // ****************************************
    // Monitors and timeout
    // ****************************************
    // Sampled on the falling edge so flop updates have settled
    always @(negedge clk_in) begin
        s_q <= smp;
        i_q <= irq;
        if (s_q === 1'b1 && smp === 1'b0) t_fall <= cyc;
        if (i_q === 1'b0 && irq === 1'b1) bits_len <= cyc - t_fall;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures++;
            final_report();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        avs_writedata_in <= {24'h0, d};
        // Request stands until waitrequest is seen low at a rising edge
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string n, input logic [9:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(n, {24'h0, q}, {24'h0, e});
    endtask
    task automatic wait_done();
        logic [7:0] q;
        q = 8'h00;
        for (int i = 0; i < 400 && q[4] !== 1'b1; i++) bus(1'b0, A_CL, 8'h00, q);
        check("done_seen", {31'h0, q[4]}, 32'h1);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_in);
        tim[i] <= 1'b1;
        @(posedge clk_in);
        tim[i] <= 1'b0;
        repeat (4) @(negedge clk_in);
    endtask
    function automatic logic [15:0] place(input logic [11:0] v, input logic al);
        return al ? {4'h0, v} : {v, 4'h0};
    endfunction
    task automatic soft_conv(input logic [3:0] ch, input logic al, input logic [1:0] dv);
        logic [15:0] e;
        e = place(level[ch], al);
        wr(A_CH, {2'b10, 3'b000, al, dv});
        wr(A_CL, {4'hC, ch});
        rd_chk("ctrl_high", A_CH, {2'b00, 3'b000, al, dv});
        rd_chk("ctrl_low_busy", A_CL, {4'h8, ch});
        wait_done();
        check("bits_len", bits_len, 48 << dv);
        check("irq_out", irq, 1'b1);
        rd_chk("result_high", A_RH, e[15:8]);
        rd_chk("result_low", A_RL, e[7:0]);
        rd_chk("irq_status", A_ST, 8'h01);
    endtask
    task automatic clear_irq(input int how);
        case (how % 3)
            0: wr(A_CLR, 8'h01);
            1: wr(A_CH, 8'h00);
            default: begin
                @(posedge clk_in);
                irq_ack_in <= 1'b1;
                @(posedge clk_in);
                irq_ack_in <= 1'b0;
            end
        endcase
        @(negedge clk_in);
        check("irq_cleared", irq, 1'b0);
    endtask
    task automatic hw_conv(input int k);
        logic [15:0] e;
        e = place(level[5], 1'b0);
        wr(A_CH, {2'b10, k[2:0], 3'b000});
        wr(A_CL, 8'hC5);
        pulse(k % 5);
        check("wrong_source_idle", smp, 1'b0);
        pulse(k - 1);
        wait_done();
        rd_chk("hw_result_high", A_RH, e[15:8]);
        rd_chk("hw_result_low", A_RL, e[7:0]);
    endtask
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        for (int i = 0; i < 16; i++) level[i] = 12'($random(seed));
        level[15] = 12'hFFF;
        level[3] = 12'h000;
        repeat (12) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd_chk("ctrl_low_reset", A_CL, 8'h00);
        rd_chk("ctrl_high_reset", A_CH, 8'h00);
        wr(10'h3F0, 8'hFF);
        rd_chk("unmapped", 10'h3F0, 8'h00);
        wr(A_EN, 8'h01);
        for (int i = 0; i < 8; i++) begin
            soft_conv(i == 0 ? 4'hF : 4'($random(seed)), i[0], i[2:1]);
            clear_irq(i);
        end
        $display("software start test done");
        wr(A_CL, 8'hA5);
        repeat (4) @(negedge clk_in);
        check("zero_start_no_effect", smp, 1'b0);
        check("ref_select", refs, 1'b1);
        for (int k = 1; k <= 5; k++) begin
            hw_conv(k);
            clear_irq(k);
        end
        $display("hardware trigger test done");
        wr(A_CL, 8'h05);
        rd_chk("done_power_off", A_CL, 8'h05);
        pulse(4);
        check("off_no_start", smp, 1'b0);
        soft_conv(4'h3, 1'b0, 2'b00);
        @(posedge clk_in);
        stop_mode_in <= 1'b1;
        @(posedge clk_in);
        stop_mode_in <= 1'b0;
        rd_chk("done_stop", A_CL, 8'h03);
        $display("power and stop test done");
        final_report();
    end
endmodule
